// *** exec_pkg.sv ***
// Constants, register map and types shared by the execution block and its ALU
package exec_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int ICYCLE_NS       = 20;
  localparam int CLKS_PER_ICYCLE = (ICYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STALL_EDGES     = 2;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int PC_W       = 13;
  localparam int BYTE_W     = 8;
  localparam int FILE_DEPTH = 128;
  localparam int FILE_AW    = 7;
  localparam int JUMP_W     = 11;
  localparam int OP_W       = 3;
  localparam int CNT_W      = 4;
  localparam int ICYC_W     = 2;
  localparam int BE_W       = 4;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [ADDR_W-1:0] OFF_INSTR  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ACCUM  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PC     = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_LATCH  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CYCLES = 12'h014;
  localparam int                FILE_REGION_LSB = 9;
  localparam logic [2:0]        FILE_REGION     = 3'h1;
  localparam int                FILE_IDX_LSB    = 2;

  // ****************************************
  // Instruction word fields
  // ****************************************
  localparam int OP_LSB    = 16;
  localparam int DEST_BIT  = 7;
  localparam int LATCH_HI  = 4;
  localparam int LATCH_LO  = 3;

  localparam logic [OP_W-1:0] OPC_NOP          = 3'h0;
  localparam logic [OP_W-1:0] OPC_JUMP         = 3'h1;
  localparam logic [OP_W-1:0] OPC_INC_SKIP     = 3'h2;
  localparam logic [OP_W-1:0] OPC_OR_LITERAL   = 3'h3;
  localparam logic [OP_W-1:0] OPC_INC_FILE     = 3'h4;
  localparam logic [OP_W-1:0] OPC_OR_WITH_FILE = 3'h5;

  // ****************************************
  // Status bits, steps and reset values
  // ****************************************
  localparam int STAT_ZERO_BIT    = 0;
  localparam int STAT_SKIP_BIT    = 1;
  localparam int STAT_ILLEGAL_BIT = 2;

  localparam logic [ICYC_W-1:0] ICYC_ONE     = 2'h1;
  localparam logic [ICYC_W-1:0] ICYC_TWO     = 2'h2;
  localparam logic [PC_W-1:0]   PC_STEP      = 13'h0001;
  localparam logic [PC_W-1:0]   PC_SKIP_STEP = 13'h0002;
  localparam logic [BYTE_W-1:0] BYTE_ONE     = 8'h01;
  localparam logic [BYTE_W-1:0] BYTE_ZERO    = 8'h00;

  localparam logic [BYTE_W-1:0] ACCUM_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] LATCH_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] FILE_RST   = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE    = 4'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} bus_state_t;

endpackage

// *** exec_if.sv ***
// Carrier between the execution control and its ALU
`timescale 1ns/1ps
`default_nettype none
interface exec_if;
  import exec_pkg::*;

  logic [OP_W-1:0]   op;
  logic [JUMP_W-1:0] operand;
  logic [BYTE_W-1:0] accum;
  logic [BYTE_W-1:0] fdata;
  logic [PC_W-1:0]   pc;
  logic [BYTE_W-1:0] latch;
  logic [BYTE_W-1:0] result;
  logic              wr_accum;
  logic              wr_file;
  logic              zero_upd;
  logic              zero_val;
  logic              skip;
  logic              illegal;
  logic [PC_W-1:0]   next_pc;
  logic [ICYC_W-1:0] icycles;

  modport ctrl (
    output op, operand, accum, fdata, pc, latch,
    input  result, wr_accum, wr_file, zero_upd, zero_val, skip, illegal, next_pc, icycles
  );
  modport alu (
    input  op, operand, accum, fdata, pc, latch,
    output result, wr_accum, wr_file, zero_upd, zero_val, skip, illegal, next_pc, icycles
  );
endinterface
`default_nettype wire

// *** exec_alu.sv ***
// Combinational result, destination, flag and next-address logic
`timescale 1ns/1ps
`default_nettype none
module exec_alu
  import exec_pkg::*;
(
  // Operands in, results out
  exec_if.alu x
);

  logic [BYTE_W-1:0] inc_val;
  logic              dest_file;

  // Wraps from all ones to zero
  assign inc_val   = x.fdata + BYTE_ONE;
  assign dest_file = x.operand[DEST_BIT];

  always_comb begin
    x.result   = BYTE_ZERO;
    x.wr_accum = 1'b0;
    x.wr_file  = 1'b0;
    x.zero_upd = 1'b0;
    x.skip     = 1'b0;
    x.illegal  = 1'b0;
    x.next_pc  = x.pc + PC_STEP;
    x.icycles  = ICYC_ONE;
    case (x.op)
      OPC_NOP: begin
      end
      OPC_JUMP: begin
        x.next_pc = {x.latch[LATCH_HI:LATCH_LO], x.operand};
        x.icycles = ICYC_TWO;
      end
      OPC_INC_SKIP: begin
        x.result   = inc_val;
        x.wr_accum = !dest_file;
        x.wr_file  = dest_file;
        if (inc_val == BYTE_ZERO) begin
          // Skipped slot becomes a no-op, so the address steps past it
          x.skip    = 1'b1;
          x.next_pc = x.pc + PC_SKIP_STEP;
          x.icycles = ICYC_TWO;
        end
      end
      OPC_OR_LITERAL: begin
        x.result   = x.accum | x.operand[BYTE_W-1:0];
        x.wr_accum = 1'b1;
        x.zero_upd = 1'b1;
      end
      OPC_INC_FILE: begin
        x.result   = inc_val;
        x.wr_accum = !dest_file;
        x.wr_file  = dest_file;
        x.zero_upd = 1'b1;
      end
      OPC_OR_WITH_FILE: begin
        x.result   = x.accum | x.fdata;
        x.wr_accum = !dest_file;
        x.wr_file  = dest_file;
        x.zero_upd = 1'b1;
      end
      default: begin
        x.illegal = 1'b1;
      end
    endcase
  end

  assign x.zero_val = (x.result == BYTE_ZERO);

endmodule
`default_nettype wire

// *** branch_increment_or_execute.sv ***
// Instruction execution block for jump, increment and inclusive-OR, with an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
module branch_increment_or_execute
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [BE_W-1:0]   avs_byteenable,
  output var  logic [DATA_W-1:0] avs_readdata,
  output var  logic              avs_waitrequest,
  // Core state
  output var  logic [PC_W-1:0]   program_counter,
  output var  logic [BYTE_W-1:0] accumulator,
  output var  logic              zero_flag
);

  // ****************************************
  // Storage
  // ****************************************
  bus_state_t        state;
  logic [CNT_W-1:0]  cnt;
  logic [BYTE_W-1:0] latch_high;
  logic [BYTE_W-1:0] file_q [FILE_DEPTH];
  logic [DATA_W-1:0] last_instr;
  logic [ICYC_W-1:0] last_cycles;
  logic              skip_taken;
  logic              illegal_seen;

  // ****************************************
  // Decode
  // ****************************************
  logic              sel_instr;
  logic              sel_accum;
  logic              sel_status;
  logic              sel_pc;
  logic              sel_latch;
  logic              sel_cycles;
  logic              sel_file;
  logic [FILE_AW-1:0] file_idx;
  logic              commit;
  logic              exec_commit;
  logic              bus_commit;
  logic [DATA_W-1:0] rd_value;

  assign sel_instr  = (avs_address == OFF_INSTR);
  assign sel_accum  = (avs_address == OFF_ACCUM);
  assign sel_status = (avs_address == OFF_STATUS);
  assign sel_pc     = (avs_address == OFF_PC);
  assign sel_latch  = (avs_address == OFF_LATCH);
  assign sel_cycles = (avs_address == OFF_CYCLES);
  assign sel_file   = (avs_address[ADDR_W-1:FILE_REGION_LSB] == FILE_REGION)
                   && (avs_address[FILE_IDX_LSB-1:0] == 2'h0);
  assign file_idx   = avs_address[FILE_IDX_LSB +: FILE_AW];

  // Writes act only on the edge at which the master sees waitrequest low
  assign commit      = (state == ST_DONE) && avs_write;
  assign exec_commit = commit && sel_instr;
  assign bus_commit  = commit && !sel_instr;

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [BE_W-1:0]   be);
    logic [DATA_W-1:0] m;
    m = old_v;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        m[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
      end
    end
    return m;
  endfunction

  logic [DATA_W-1:0] m_accum;
  logic [DATA_W-1:0] m_pc;
  logic [DATA_W-1:0] m_latch;
  logic [DATA_W-1:0] m_file;

  assign m_accum = merge({24'h00_0000, accumulator}, avs_writedata, avs_byteenable);
  assign m_pc    = merge({19'h0_0000, program_counter}, avs_writedata, avs_byteenable);
  assign m_latch = merge({24'h00_0000, latch_high}, avs_writedata, avs_byteenable);
  assign m_file  = merge({24'h00_0000, file_q[file_idx]}, avs_writedata, avs_byteenable);

  // ****************************************
  // ALU hookup
  // ****************************************
  exec_if x ();

  assign x.op      = avs_writedata[OP_LSB +: OP_W];
  assign x.operand = avs_writedata[JUMP_W-1:0];
  assign x.accum   = accumulator;
  assign x.fdata   = file_q[x.operand[FILE_AW-1:0]];
  assign x.pc      = program_counter;
  assign x.latch   = latch_high;

  exec_alu u_alu (
    .x (x.alu)
  );

  // ****************************************
  // Bus handshake
  // ****************************************
  logic              take_instr;
  logic              take_plain;
  logic              stall_end;
  logic [CNT_W-1:0]  stall_len;

  assign take_instr = (state == ST_IDLE) && avs_write && sel_instr;
  assign take_plain = (state == ST_IDLE) && (avs_read || avs_write) && !take_instr;
  assign stall_end  = (state == ST_EXEC) && (cnt == CNT_ZERO);
  // Taking and answering edges are part of the instruction's time
  assign stall_len  = CNT_W'(int'(x.icycles) * CLKS_PER_ICYCLE - STALL_EDGES);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take_instr) begin
            state <= ST_EXEC;
          end else if (take_plain) begin
            state <= ST_DONE;
          end
        end
        ST_EXEC: begin
          if (stall_end) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Stall for the instruction's whole duration in clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_ZERO;
    end else if (take_instr) begin
      cnt <= stall_len;
    end else if (state == ST_EXEC && cnt != CNT_ZERO) begin
      cnt <= cnt - CNT_ONE;
    end
  end

  // Low for the one cycle in which the master completes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (take_plain || stall_end) begin
      avs_waitrequest <= 1'b0;
    end else if (state == ST_DONE) begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    rd_value = WORD_ZERO;
    if (sel_instr) begin
      rd_value = last_instr;
    end else if (sel_accum) begin
      rd_value[BYTE_W-1:0] = accumulator;
    end else if (sel_status) begin
      rd_value[STAT_ZERO_BIT]    = zero_flag;
      rd_value[STAT_SKIP_BIT]    = skip_taken;
      rd_value[STAT_ILLEGAL_BIT] = illegal_seen;
    end else if (sel_pc) begin
      rd_value[PC_W-1:0] = program_counter;
    end else if (sel_latch) begin
      rd_value[BYTE_W-1:0] = latch_high;
    end else if (sel_cycles) begin
      rd_value[ICYC_W-1:0] = last_cycles;
    end else if (sel_file) begin
      rd_value[BYTE_W-1:0] = file_q[file_idx];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= WORD_ZERO;
    end else if (state == ST_IDLE && avs_read) begin
      avs_readdata <= rd_value;
    end
  end

  // ****************************************
  // Core registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator <= ACCUM_RST;
    end else if (exec_commit && x.wr_accum) begin
      accumulator <= x.result;
    end else if (bus_commit && sel_accum) begin
      accumulator <= m_accum[BYTE_W-1:0];
    end
  end

  // Jump and increment-skip leave the flag untouched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_flag <= 1'b0;
    end else if (exec_commit && x.zero_upd) begin
      zero_flag <= x.zero_val;
    end else if (bus_commit && sel_status && avs_byteenable[0]) begin
      zero_flag <= avs_writedata[STAT_ZERO_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= PC_RST;
    end else if (exec_commit) begin
      program_counter <= x.next_pc;
    end else if (bus_commit && sel_pc) begin
      program_counter <= m_pc[PC_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_high <= LATCH_RST;
    end else if (bus_commit && sel_latch) begin
      latch_high <= m_latch[BYTE_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_instr <= WORD_ZERO;
    end else if (exec_commit) begin
      last_instr <= avs_writedata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_cycles <= ICYC_ONE;
    end else if (exec_commit) begin
      last_cycles <= x.icycles;
    end
  end

  // Only the last instruction's skip is kept
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_taken <= 1'b0;
    end else if (exec_commit) begin
      skip_taken <= x.skip;
    end
  end

  // Sticky; a new illegal code in the clearing cycle keeps it set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      illegal_seen <= 1'b0;
    end else if (exec_commit && x.illegal) begin
      illegal_seen <= 1'b1;
    end else if (bus_commit && sel_status && avs_byteenable[0]
                 && avs_writedata[STAT_ILLEGAL_BIT]) begin
      illegal_seen <= 1'b0;
    end
  end

  // ****************************************
  // File registers
  // ****************************************
  for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        file_q[i] <= FILE_RST;
      end else if (exec_commit && x.wr_file && x.operand[FILE_AW-1:0] == FILE_AW'(i)) begin
        file_q[i] <= x.result;
      end else if (bus_commit && sel_file && file_idx == FILE_AW'(i)) begin
        file_q[i] <= m_file[BYTE_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// *** exec_assertions.sv ***
// Port-level checks for the jump, increment and inclusive-OR execution block
`timescale 1ns/1ps
`default_nettype none
module exec_assertions
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // Register bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [BE_W-1:0]   avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Core state
  input wire logic [PC_W-1:0]   program_counter,
  input wire logic [BYTE_W-1:0] accumulator,
  input wire logic              zero_flag
);
  logic              done;
  logic [OP_W-1:0]   op;
  logic              dst;
  logic [JUMP_W-1:0] lit11;
  logic [BYTE_W-1:0] lit8;
  logic [BYTE_W-1:0] latch;
  logic [1:0]        latch_hi;
  logic [CNT_W-1:0]  wait_cnt;

  assign done     = avs_write && !avs_waitrequest && (avs_address == OFF_INSTR);
  assign op       = avs_writedata[OP_LSB +: OP_W];
  assign dst      = avs_writedata[DEST_BIT];
  assign lit11    = avs_writedata[JUMP_W-1:0];
  assign lit8     = avs_writedata[BYTE_W-1:0];
  assign latch_hi = latch[LATCH_HI:LATCH_LO];

  // Shadow of the latch-high register, as seen on the bus
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= LATCH_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == OFF_LATCH
                 && avs_byteenable[0]) begin
      latch <= lit8;
    end
  end

  // Stalled cycles of the instruction write in flight
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= CNT_ZERO;
    end else if (avs_write && avs_waitrequest && avs_address == OFF_INSTR) begin
      wait_cnt <= wait_cnt + CNT_ONE;
    end else begin
      wait_cnt <= CNT_ZERO;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_jump_low;
    done && op == OPC_JUMP |=> program_counter[JUMP_W-1:0] == $past(lit11);
  endproperty
  a_jump_low: assert property (p_jump_low) else $error("jump low bits wrong");
  property p_jump_high;
    done && op == OPC_JUMP |=> program_counter[PC_W-1:JUMP_W] == $past(latch_hi);
  endproperty
  a_jump_high: assert property (p_jump_high) else $error("jump high bits wrong");
  property p_jump_flags;
    done && op == OPC_JUMP |=> $stable(zero_flag) && $stable(accumulator);
  endproperty
  a_jump_flags: assert property (p_jump_flags) else $error("jump touched state");
  property p_jump_time;
    done && op == OPC_JUMP |-> wait_cnt == CNT_W'(2 * CLKS_PER_ICYCLE);
  endproperty
  a_jump_time: assert property (p_jump_time) else $error("jump length wrong");
  property p_one_cycle;
    done && (op == OPC_OR_LITERAL || op == OPC_INC_FILE || op == OPC_OR_WITH_FILE)
      |-> wait_cnt == CNT_W'(CLKS_PER_ICYCLE);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("one-cycle op length wrong");
  property p_or_lit;
    done && op == OPC_OR_LITERAL |=> accumulator == ($past(accumulator) | $past(lit8))
      && zero_flag == (accumulator == BYTE_ZERO);
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal result wrong");
  property p_skip_flags;
    done && op == OPC_INC_SKIP |=> $stable(zero_flag);
  endproperty
  a_skip_flags: assert property (p_skip_flags) else $error("skip touched zero");
  property p_skip_pc;
    done && op == OPC_INC_SKIP && !dst |=> program_counter == $past(program_counter)
      + ((accumulator == BYTE_ZERO) ? PC_SKIP_STEP : PC_STEP);
  endproperty
  a_skip_pc: assert property (p_skip_pc) else $error("skip step wrong");
  property p_increment_file_zero;
    done && op == OPC_INC_FILE && !dst |=> zero_flag == (accumulator == BYTE_ZERO);
  endproperty
  a_increment_file_zero: assert property (p_increment_file_zero) else $error("increment zero wrong");
  property p_orwf;
    done && op == OPC_OR_WITH_FILE && !dst |=> (accumulator | $past(accumulator)) == accumulator
      && zero_flag == (accumulator == BYTE_ZERO);
  endproperty
  a_orwf: assert property (p_orwf) else $error("or with file wrong");
endmodule

bind branch_increment_or_execute exec_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .program_counter(program_counter), .accumulator(accumulator), .zero_flag(zero_flag)
);
`default_nettype wire

// *** tb_branch_increment_or_execute.sv ***
// Self-checking bench for the jump, increment and inclusive-OR execution block
`timescale 1ns/1ps
`default_nettype none
module tb_branch_increment_or_execute;
  import exec_pkg::*;
  localparam int TIMEOUT_CYC = 5000;
  logic              sys_clk;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0]   avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [PC_W-1:0]   program_counter;
  logic [BYTE_W-1:0] accumulator;
  logic              zero_flag;
  logic [DATA_W-1:0] rd;
  logic [PC_W-1:0]   pc0;
  int                err_total = 0;
  int                num_checks = 0;
  int                cyc = 0;

  branch_increment_or_execute u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .program_counter(program_counter), .accumulator(accumulator), .zero_flag(zero_flag)
  );

  initial begin
    sys_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2.0) sys_clk = ~sys_clk;
  end

  // ****************************************
  // Bench services
  // ****************************************
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Request stands until the rising edge at which waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [BE_W-1:0] be);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, WORD_ZERO, 4'hF);
    check(rd, exp);
  endtask

  function automatic logic [DATA_W-1:0] ins(input logic [OP_W-1:0] op, input logic [10:0] lo);
    return {13'h0000, op, 5'h00, lo};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check(program_counter, PC_RST);
    check(accumulator, ACCUM_RST);
    check(zero_flag, 1'b0);
    rd_chk(12'hFF0, WORD_ZERO);
    bus(1'b1, OFF_STATUS, 32'h0000_0001, 4'hE);
    check(zero_flag, 1'b0);
  endtask

  task automatic t_jump();
    wr(OFF_STATUS, 32'h0000_0001);
    wr(OFF_LATCH, 32'h0000_00E8);
    wr(OFF_INSTR, ins(OPC_JUMP, 11'h7FF));
    check(program_counter, 13'h0FFF);
    check(zero_flag, 1'b1);
    rd_chk(OFF_CYCLES, 32'h0000_0002);
    wr(OFF_LATCH, 32'h0000_0017);
    wr(OFF_INSTR, ins(OPC_JUMP, 11'h000));
    check(program_counter, 13'h1000);
  endtask

  task automatic t_or_lit();
    wr(OFF_ACCUM, WORD_ZERO);
    wr(OFF_STATUS, WORD_ZERO);
    pc0 = program_counter;
    wr(OFF_INSTR, ins(OPC_OR_LITERAL, 11'h000));
    check(zero_flag, 1'b1);
    check(program_counter, PC_W'(pc0 + PC_STEP));
    wr(OFF_INSTR, ins(OPC_OR_LITERAL, 11'h7A5));
    check(accumulator, 8'hA5);
    check(zero_flag, 1'b0);
    wr(OFF_INSTR, ins(OPC_OR_LITERAL, 11'h05A));
    check(accumulator, 8'hFF);
    rd_chk(OFF_CYCLES, 32'h0000_0001);
  endtask

  task automatic t_increment_file();
    wr(OFF_ACCUM, 32'h0000_0033);
    wr(12'h3FC, 32'h0000_00FF);
    wr(OFF_INSTR, ins(OPC_INC_FILE, 11'h0FF));
    rd_chk(12'h3FC, WORD_ZERO);
    check(zero_flag, 1'b1);
    check(accumulator, 8'h33);
    wr(OFF_INSTR, ins(OPC_INC_FILE, 11'h07F));
    check(accumulator, 8'h01);
    check(zero_flag, 1'b0);
    rd_chk(12'h3FC, WORD_ZERO);
  endtask

  task automatic t_skip();
    wr(OFF_STATUS, WORD_ZERO);
    wr(12'h214, 32'h0000_00FE);
    pc0 = program_counter;
    wr(OFF_INSTR, ins(OPC_INC_SKIP, 11'h085));
    rd_chk(12'h214, 32'h0000_00FF);
    check(program_counter, PC_W'(pc0 + PC_STEP));
    rd_chk(OFF_CYCLES, 32'h0000_0001);
    pc0 = program_counter;
    wr(OFF_INSTR, ins(OPC_INC_SKIP, 11'h005));
    check(accumulator, 8'h00);
    check(zero_flag, 1'b0);
    rd_chk(12'h214, 32'h0000_00FF);
    check(program_counter, PC_W'(pc0 + PC_SKIP_STEP));
    rd_chk(OFF_CYCLES, 32'h0000_0002);
  endtask

  task automatic t_orwf();
    wr(OFF_ACCUM, 32'h0000_000F);
    wr(12'h20C, 32'h0000_00F0);
    wr(OFF_INSTR, ins(OPC_OR_WITH_FILE, 11'h003));
    check(accumulator, 8'hFF);
    check(zero_flag, 1'b0);
    rd_chk(12'h20C, 32'h0000_00F0);
    wr(OFF_ACCUM, WORD_ZERO);
    wr(OFF_INSTR, ins(OPC_OR_WITH_FILE, 11'h089));
    rd_chk(12'h224, WORD_ZERO);
    check(zero_flag, 1'b1);
    wr(OFF_ACCUM, 32'h0000_003C);
    wr(OFF_INSTR, ins(OPC_OR_WITH_FILE, 11'h083));
    rd_chk(12'h20C, 32'h0000_00FC);
    check(accumulator, 8'h3C);
  endtask

  task automatic t_misc();
    wr(OFF_STATUS, WORD_ZERO);
    pc0 = program_counter;
    wr(OFF_INSTR, ins(OPC_NOP, 11'h7FF));
    check(program_counter, PC_W'(pc0 + PC_STEP));
    check(accumulator, 8'h3C);
    wr(OFF_INSTR, ins(3'h7, 11'h000));
    check(program_counter, PC_W'(pc0 + PC_STEP + PC_STEP));
    rd_chk(OFF_CYCLES, 32'h0000_0001);
    rd_chk(OFF_STATUS, 32'h0000_0004);
    wr(OFF_STATUS, 32'h0000_0004);
    rd_chk(OFF_STATUS, WORD_ZERO);
  endtask

  initial begin
    rst_n          = 1'b0;
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = WORD_ZERO;
    avs_byteenable = 4'hF;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_jump();
    t_or_lit();
    t_increment_file();
    t_skip();
    t_orwf();
    t_misc();
    stop_test();
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc >= TIMEOUT_CYC) begin
      err_total++;
      stop_test();
    end
  end
endmodule
`default_nettype wire
